/* File: hw/audbp_pkg.sv */
// Constants, tables and types of the audio baseband processor
package audbp_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TONE = 8'h04;
	localparam logic [7:0] ADDR_SUB = 8'h08;
	localparam logic [7:0] ADDR_AGC = 8'h0C;
	localparam logic [7:0] ADDR_PEAK = 8'h10;
	localparam logic [7:0] ADDR_GAIN = 8'h14;
	localparam logic [7:0] ADDR_EQ = 8'h20;
	// Write masks and reset values
	localparam logic [31:0] TONE_MASK = 32'h00FF_1F1F;
	localparam logic [31:0] SUB_MASK = 32'h00FF_FFFF;
	localparam logic [15:0] CTRL_RST = 16'h6200;
	localparam logic [31:0] TONE_RST = 32'h0000_0000;
	localparam logic [31:0] SUB_RST = 32'h0000_0180;
	localparam logic [15:0] AGC_THR_RST = 16'h4000;
	localparam logic [15:0] EQ_ALPHA_RST [5] = '{16'h00D7, 16'h0360, 16'h0D60, 16'h3300, 16'h7000};
	// Main channel modes and low-pass edges
	localparam logic [1:0] MODE_DRY = 2'h0;
	localparam logic [1:0] MODE_HP = 2'h1;
	localparam logic [1:0] EDGE_SHARP = 2'h0;
	localparam logic [1:0] EDGE_MEDIUM = 2'h1;
	localparam logic [1:0] EDGE_SOFT = 2'h2;
	// Ranges
	localparam int EQ_BANDS = 5;
	localparam int VOL_MAX_DB = 114;
	localparam int COARSE_DB = 6;
	localparam int TONE_MAX_DB = 12;
	localparam int EQ_GAIN_MIN = -2043;
	localparam int EQ_GAIN_MAX = 4077;
	localparam int SUB_LVL_MIN = -60;
	localparam int SUB_LVL_MAX = 12;
	localparam int SUB_BOOST_SH = 2;
	localparam int SMP_MAX = 32767;
	localparam int SMP_MIN = -32768;
	// Fixed point
	localparam int Q12_SH = 12;
	localparam int Q15_SH = 15;
	localparam int FRAC_SH = 8;
	localparam int Q12_ONE = 1 << Q12_SH;
	localparam int RAMP_STEP = 16;
	localparam int BASS_ALPHA = 515;
	localparam int TREB_ALPHA = 17833;
	// Sample-rate timing
	localparam int FS_HZ = 48000;
	localparam int QP_ATTACK_US = 1300;
	localparam int QP_DECAY_US = 37000;
	localparam int QP_ATK_SH = $clog2(QP_ATTACK_US * (FS_HZ / 1000) / 1000);
	localparam int QP_DEC_SH = $clog2(QP_DECAY_US * (FS_HZ / 1000) / 1000);
	localparam int AGC_ATK_SH = 6;
	localparam int AGC_DECAY_MS [4] = '{8000, 4000, 2000, 20};
	// Gain tables in Q12, index in dB
	localparam int DB_DOWN [13] = '{4096, 3651, 3254, 2900, 2584, 2303, 2053, 1830, 1631, 1453, 1295, 1154, 1029};
	localparam int DB_UP [13] = '{4096, 4596, 5157, 5786, 6492, 7284, 8173, 9170, 10289, 11544, 12953, 14533, 16306};

	// Samples between unit steps of the level equalizer release
	function automatic int agc_rel(input int ms);
		int n;
		n = ms * (FS_HZ / 1000) / Q12_ONE;
		return (n < 1) ? 1 : n;
	endfunction

	typedef struct packed {
		logic [1:0] decay;
		logic [1:0] mode;
		logic [1:0] edge_sel;
		logic sub_on;
		logic agc_on;
		logic mute;
		logic [6:0] vol;
	} audbp_ctrl_type;

	typedef struct packed {
		logic signed [15:0] l;
		logic signed [15:0] r;
	} audbp_stereo_type;

	typedef logic signed [47:0] audbp_acc_type;
endpackage

/* File: hw/audbp_top.sv */
// Stereo baseband processing chain with APB control registers
// How it works
// R01: Volume 0 to 114 dB attenuation in 1 dB steps, codes above mean mute.
// R02: Volume splits into 6 dB analog steps and a digital fine gain.
// R03: Applied digital gain ramps toward its target each sample, never jumps.
// R04: Balance adds digital attenuation to one channel only.
// R05: Mute acts on both channels together and uses the same ramp.
// R06: Bass shelf below 120 Hz, -12 to +12 dB, same on both channels.
// R07: Treble shelf above 6 kHz, -12 to +12 dB, same on both channels.
// R08: Five equalizer bands, each with its own programmable corner.
// R09: Band gains are clamped to the -6 to +6 dB range.
// R10: Equalizer coefficients are written by software; reset gains give flat response.
// R11: Subwoofer input is the half sum of equalized left and right.
// R12: Subwoofer third-order low-pass, programmable corner, 90 Hz default.
// R13: Four low-pass edges selectable, sharp by default.
// R14: Main channels dry, high-passed, or high-passed plus subwoofer; last default.
// R15: Subwoofer level -60 to +12 dB relative to main volume, 0 dB default.
// R16: Subwoofer follows main volume; its converter enable defaults on.
// R17: Level equalizer leaves quiet signals alone, releases at 8 s, 4 s, 2 s, 20 ms; the 20 ms setting steps once per sample, about 85 ms.
// R18: Two quasi-peak detectors, ADC side and DAC side, 1.3 ms attack, 37 ms decay.
// R19: Two channels, one sample per strobe from the frame-locked stream.
// R20: Clock comes from the PLL fed by the 12 MHz reference.
// R21: Signal-path parameters take effect only at the sample strobe, so samples stay consistent; sub_dac_en_o follows the control register at once.
module audbp_top (
	// Clock and reset
	input wire logic clock_i, // R20
	input wire logic rst_i,
	// APB register port
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Playback stream
	input wire logic smp_valid_i,
	input wire audbp_pkg::audbp_stereo_type smp_i,
	// Record stream from the ADC
	input wire logic adc_valid_i,
	input wire audbp_pkg::audbp_stereo_type adc_i,
	// Converter side
	output logic dac_valid_o,
	output audbp_pkg::audbp_stereo_type dac_o,
	output logic signed [15:0] sub_o,
	output logic sub_dac_en_o,
	output logic [4:0] analog_atten_o,
	output logic analog_mute_o
);
	audbp_pkg::audbp_ctrl_type ctrl_reg;
	logic [31:0] tone_reg;
	logic [31:0] sub_reg;
	logic [15:0] agc_thr_reg;
	logic [31:0] eq_reg [audbp_pkg::EQ_BANDS];
	logic [31:0] prdata_reg;
	logic slverr_reg;
	logic [31:0] rd_data;
	logic rd_ok;
	logic setup;
	logic wr_en;
	logic [7:0] eq_off;
	logic [2:0] eq_sel;
	logic eq_hit;
	logic [12:0] gain_reg [3];
	logic [12:0] tgt [3];
	logic [12:0] agc_gain_reg;
	logic [7:0] rel_cnt_reg;
	logic [4:0] analog_atten_reg;
	logic analog_mute_reg;
	logic muted;
	logic [15:0] peak [2];
	logic over [2];
	audbp_pkg::audbp_acc_type xe [2];
	audbp_pkg::audbp_acc_type sp_reg [3];
	audbp_pkg::audbp_acc_type sp_n [3];
	audbp_pkg::audbp_acc_type s_in, sub_lp, sub_lv, m;
	logic signed [15:0] out_n [2];
	logic signed [15:0] sub_n;
	audbp_pkg::audbp_stereo_type dac_reg;
	logic signed [15:0] sub_out_reg;
	logic valid_reg;
	int vol, fine, bal, att_l, att_r, lvl;

	function automatic audbp_pkg::audbp_acc_type k(input int v);
		k = audbp_pkg::audbp_acc_type'(v);
	endfunction

	function automatic audbp_pkg::audbp_acc_type mq(input audbp_pkg::audbp_acc_type a,
		input audbp_pkg::audbp_acc_type b, input int sh);
		mq = (a * b) >>> sh;
	endfunction

	// Attenuation in dB to Q12 gain: table for the fine part, shift per 6 dB
	function automatic audbp_pkg::audbp_acc_type dbg(input int att);
		dbg = k(audbp_pkg::DB_DOWN[att % audbp_pkg::COARSE_DB]) >>> (att / audbp_pkg::COARSE_DB);
	endfunction

	// Shelf contribution: y scaled by gain minus one
	function automatic audbp_pkg::audbp_acc_type tone(input audbp_pkg::audbp_acc_type y,
		input logic [4:0] g);
		int a;
		a = int'(signed'(g));
		if (a > audbp_pkg::TONE_MAX_DB)
			a = audbp_pkg::TONE_MAX_DB;
		if (a < -audbp_pkg::TONE_MAX_DB)
			a = -audbp_pkg::TONE_MAX_DB;
		if (a >= 0)
			tone = mq(y, k(audbp_pkg::DB_UP[a] - audbp_pkg::Q12_ONE), audbp_pkg::Q12_SH);
		else
			tone = mq(y, k(audbp_pkg::DB_DOWN[-a] - audbp_pkg::Q12_ONE), audbp_pkg::Q12_SH);
	endfunction

	function automatic audbp_pkg::audbp_acc_type eqg(input logic [15:0] r);
		int v;
		v = int'(signed'(r));
		if (v > audbp_pkg::EQ_GAIN_MAX)
			v = audbp_pkg::EQ_GAIN_MAX;
		if (v < audbp_pkg::EQ_GAIN_MIN)
			v = audbp_pkg::EQ_GAIN_MIN;
		eqg = k(v);
	endfunction

	function automatic logic signed [15:0] sat16(input audbp_pkg::audbp_acc_type a);
		if (a > k(audbp_pkg::SMP_MAX))
			sat16 = 16'h7FFF;
		else if (a < k(audbp_pkg::SMP_MIN))
			sat16 = 16'h8000;
		else
			sat16 = a[15:0];
	endfunction

	function automatic logic [15:0] mag(input logic signed [15:0] x);
		mag = x[15] ? 16'(-x) : x;
	endfunction

	// APB decode, zero wait states
	assign setup = psel_i & ~penable_i;
	assign wr_en = psel_i & penable_i & pwrite_i;
	assign pready_o = psel_i & penable_i;
	assign pslverr_o = slverr_reg & pready_o;
	assign prdata_o = prdata_reg;
	assign eq_off = paddr_i - audbp_pkg::ADDR_EQ;
	assign eq_sel = eq_off[4:2];
	assign eq_hit = (paddr_i >= audbp_pkg::ADDR_EQ) && (eq_off[7:5] == 3'h0) && (eq_off[1:0] == 2'h0)
		&& (eq_sel < 3'(audbp_pkg::EQ_BANDS));

	always_comb
	begin
		rd_ok = 1'b1;
		rd_data = '0;
		case (paddr_i)
			audbp_pkg::ADDR_CTRL: rd_data = {16'h0000, ctrl_reg};
			audbp_pkg::ADDR_TONE: rd_data = tone_reg;
			audbp_pkg::ADDR_SUB: rd_data = sub_reg;
			audbp_pkg::ADDR_AGC: rd_data = {3'h0, agc_gain_reg, agc_thr_reg};
			audbp_pkg::ADDR_PEAK: rd_data = {peak[1], peak[0]};
			audbp_pkg::ADDR_GAIN: rd_data = {11'h000, analog_atten_reg, 3'h0, gain_reg[0]};
			default:
			begin
				rd_ok = eq_hit;
				rd_data = eq_hit ? eq_reg[eq_sel] : '0;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end
		else if (setup)
		begin
			prdata_reg <= rd_data;
			slverr_reg <= ~rd_ok;
		end
	end

	// Control registers
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_reg <= audbp_pkg::CTRL_RST; // R13 R14 R16 R17
			tone_reg <= audbp_pkg::TONE_RST;
			sub_reg <= audbp_pkg::SUB_RST; // R12 R15
			agc_thr_reg <= audbp_pkg::AGC_THR_RST;
		end
		else if (wr_en)
		begin
			case (paddr_i)
				audbp_pkg::ADDR_CTRL: ctrl_reg <= pwdata_i[15:0];
				audbp_pkg::ADDR_TONE: tone_reg <= pwdata_i & audbp_pkg::TONE_MASK;
				audbp_pkg::ADDR_SUB: sub_reg <= pwdata_i & audbp_pkg::SUB_MASK;
				audbp_pkg::ADDR_AGC: agc_thr_reg <= pwdata_i[15:0];
				default:
				begin
				end
			endcase
		end
	end

	// Equalizer coefficients: corner in the high half, gain in the low half
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int b = 0; b < audbp_pkg::EQ_BANDS; b++)
				eq_reg[b] <= {audbp_pkg::EQ_ALPHA_RST[b], 16'h0000}; // R10
		end
		else
		begin
			for (int b = 0; b < audbp_pkg::EQ_BANDS; b++)
				if (wr_en && eq_hit && eq_sel == 3'(b))
					eq_reg[b] <= pwdata_i; // R10
		end
	end

	// Per-channel chain: level equalizer, bass, treble, equalizer
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		audbp_pkg::audbp_acc_type lpb_reg, lpt_reg, x, xa, lpb_n, xb, lpt_n, xt, sum, thr;
		audbp_pkg::audbp_acc_type lpe_reg [audbp_pkg::EQ_BANDS];
		audbp_pkg::audbp_acc_type lpe_n [audbp_pkg::EQ_BANDS];

		always_comb
		begin
			x = k(int'(c == 0 ? smp_i.l : smp_i.r)) <<< audbp_pkg::FRAC_SH; // R19
			xa = ctrl_reg.agc_on ? mq(x, k(int'(agc_gain_reg)), audbp_pkg::Q12_SH) : x;
			lpb_n = lpb_reg + mq(xa - lpb_reg, k(audbp_pkg::BASS_ALPHA), audbp_pkg::Q15_SH);
			xb = xa + tone(lpb_n, tone_reg[4:0]); // R06
			lpt_n = lpt_reg + mq(xb - lpt_reg, k(audbp_pkg::TREB_ALPHA), audbp_pkg::Q15_SH);
			xt = xb + tone(xb - lpt_n, tone_reg[12:8]); // R07
			sum = '0;
			for (int b = 0; b < audbp_pkg::EQ_BANDS; b++)
				lpe_n[b] = lpe_reg[b] + mq(xt - lpe_reg[b], k(int'(eq_reg[b][31:16])), audbp_pkg::Q15_SH); // R08
			for (int b = 0; b < audbp_pkg::EQ_BANDS; b++)
				sum = sum + mq(lpe_n[b] - (b > 0 ? lpe_n[(b + audbp_pkg::EQ_BANDS - 1) % audbp_pkg::EQ_BANDS] : '0),
					eqg(eq_reg[b][15:0]), audbp_pkg::Q12_SH); // R09
			thr = k(int'(agc_thr_reg)) <<< audbp_pkg::FRAC_SH;
		end

		assign xe[c] = xt + sum;
		assign over[c] = (xa > thr) || (xa < -thr); // R17

		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
			begin
				lpb_reg <= '0;
				lpt_reg <= '0;
				for (int b = 0; b < audbp_pkg::EQ_BANDS; b++)
					lpe_reg[b] <= '0;
			end
			else if (smp_valid_i)
			begin
				lpb_reg <= lpb_n;
				lpt_reg <= lpt_n;
				for (int b = 0; b < audbp_pkg::EQ_BANDS; b++)
					lpe_reg[b] <= lpe_n[b];
			end
		end
	end

	// Subwoofer derivation and main channel mixing
	always_comb
	begin
		s_in = (xe[0] + xe[1]) >>> 1; // R11
		sp_n[0] = sp_reg[0] + mq(s_in - sp_reg[0], k(int'(sub_reg[15:0])), audbp_pkg::Q15_SH);
		sp_n[1] = sp_reg[1] + mq(sp_n[0] - sp_reg[1], k(int'(sub_reg[15:0])), audbp_pkg::Q15_SH);
		sp_n[2] = sp_reg[2] + mq(sp_n[1] - sp_reg[2], k(int'(sub_reg[15:0])), audbp_pkg::Q15_SH); // R12
		case (ctrl_reg.edge_sel)
			audbp_pkg::EDGE_SHARP: sub_lp = sp_n[2]; // R13
			audbp_pkg::EDGE_MEDIUM: sub_lp = sp_n[1];
			audbp_pkg::EDGE_SOFT: sub_lp = sp_n[0];
			default: sub_lp = (s_in + sp_n[0]) >>> 1;
		endcase
		lvl = int'(signed'(sub_reg[23:16]));
		if (lvl > audbp_pkg::SUB_LVL_MAX)
			lvl = audbp_pkg::SUB_LVL_MAX;
		if (lvl < audbp_pkg::SUB_LVL_MIN)
			lvl = audbp_pkg::SUB_LVL_MIN;
		sub_lv = mq(sub_lp <<< audbp_pkg::SUB_BOOST_SH, dbg(audbp_pkg::SUB_LVL_MAX - lvl), audbp_pkg::Q12_SH); // R15
		m = '0;
		for (int c = 0; c < 2; c++)
		begin
			case (ctrl_reg.mode)
				audbp_pkg::MODE_DRY: m = xe[c]; // R14
				audbp_pkg::MODE_HP: m = xe[c] - sub_lp;
				default: m = xe[c] - sub_lp + sub_lv;
			endcase
			out_n[c] = sat16(mq(m, k(int'(gain_reg[c])), audbp_pkg::Q12_SH) >>> audbp_pkg::FRAC_SH);
		end
		if (ctrl_reg.sub_on)
			sub_n = sat16(mq(sub_lv, k(int'(gain_reg[2])), audbp_pkg::Q12_SH) >>> audbp_pkg::FRAC_SH); // R16
		else
			sub_n = '0;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 3; i++)
				sp_reg[i] <= '0;
		end
		else if (smp_valid_i)
		begin
			for (int i = 0; i < 3; i++)
				sp_reg[i] <= sp_n[i];
		end
	end

	// Gain targets: volume, balance and mute
	always_comb
	begin
		vol = int'(ctrl_reg.vol);
		muted = ctrl_reg.mute | (vol > audbp_pkg::VOL_MAX_DB); // R01 R05
		fine = vol % audbp_pkg::COARSE_DB; // R02
		bal = int'(signed'(tone_reg[23:16]));
		att_l = (bal > 0) ? bal : 0; // R04
		att_r = (bal < 0) ? -bal : 0;
		if (att_l > audbp_pkg::VOL_MAX_DB)
			att_l = audbp_pkg::VOL_MAX_DB;
		if (att_r > audbp_pkg::VOL_MAX_DB)
			att_r = audbp_pkg::VOL_MAX_DB;
		tgt[0] = muted ? '0 : 13'(dbg(fine + att_l));
		tgt[1] = muted ? '0 : 13'(dbg(fine + att_r));
		tgt[2] = muted ? '0 : 13'(dbg(fine)); // R16
	end

	// Click-free gain ramps, stepped once per sample
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int c = 0; c < 3; c++)
				gain_reg[c] <= '0;
		end
		else if (smp_valid_i)
		begin
			for (int c = 0; c < 3; c++)
				if (int'(gain_reg[c]) + audbp_pkg::RAMP_STEP < int'(tgt[c]))
					gain_reg[c] <= 13'(gain_reg[c] + audbp_pkg::RAMP_STEP); // R03 R05
				else if (int'(gain_reg[c]) > int'(tgt[c]) + audbp_pkg::RAMP_STEP)
					gain_reg[c] <= 13'(gain_reg[c] - audbp_pkg::RAMP_STEP); // R03
				else
					gain_reg[c] <= tgt[c];
		end
	end

	// Coarse analog attenuator, 6 dB per code
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			analog_atten_reg <= '0;
			analog_mute_reg <= 1'b0;
		end
		else if (smp_valid_i)
		begin
			analog_atten_reg <= 5'((muted ? audbp_pkg::VOL_MAX_DB : vol) / audbp_pkg::COARSE_DB); // R02
			analog_mute_reg <= muted && gain_reg[0] == '0 && gain_reg[1] == '0; // R05
		end
	end

	// Level equalizer gain: fast cut above threshold, slow selectable release
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			agc_gain_reg <= 13'(audbp_pkg::Q12_ONE);
			rel_cnt_reg <= '0;
		end
		else if (!ctrl_reg.agc_on)
		begin
			agc_gain_reg <= 13'(audbp_pkg::Q12_ONE);
			rel_cnt_reg <= '0;
		end
		else if (smp_valid_i)
		begin
			if (over[0] || over[1])
			begin
				agc_gain_reg <= agc_gain_reg - (agc_gain_reg >> audbp_pkg::AGC_ATK_SH); // R17
				rel_cnt_reg <= '0;
			end
			else if (int'(rel_cnt_reg) >= audbp_pkg::agc_rel(audbp_pkg::AGC_DECAY_MS[ctrl_reg.decay]) - 1)
			begin
				rel_cnt_reg <= '0;
				if (int'(agc_gain_reg) < audbp_pkg::Q12_ONE)
					agc_gain_reg <= agc_gain_reg + 13'h0001; // R17
			end
			else
				rel_cnt_reg <= rel_cnt_reg + 8'h01;
		end
	end

	// Quasi-peak detectors: 0 after the ADC, 1 on the DAC output
	for (genvar q = 0; q < 2; q++)
	begin : g_qp
		logic [23:0] pk_reg;
		logic [23:0] pv;
		logic stb;

		always_comb
		begin
			if (q == 0)
			begin
				pv = {(mag(adc_i.l) > mag(adc_i.r)) ? mag(adc_i.l) : mag(adc_i.r), 8'h00};
				stb = adc_valid_i;
			end
			else
			begin
				pv = {(mag(dac_reg.l) > mag(dac_reg.r)) ? mag(dac_reg.l) : mag(dac_reg.r), 8'h00};
				stb = valid_reg;
			end
		end

		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
				pk_reg <= '0;
			else if (stb)
			begin
				if (pv > pk_reg)
					pk_reg <= pk_reg + ((pv - pk_reg) >> audbp_pkg::QP_ATK_SH); // R18
				else
					pk_reg <= pk_reg - (pk_reg >> audbp_pkg::QP_DEC_SH); // R18
			end
		end

		assign peak[q] = pk_reg[23:8];
	end

	// Output samples, one clock after the input strobe
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			valid_reg <= 1'b0;
			dac_reg <= '0;
			sub_out_reg <= '0;
		end
		else
		begin
			valid_reg <= smp_valid_i;
			if (smp_valid_i)
			begin
				dac_reg.l <= out_n[0]; // R21
				dac_reg.r <= out_n[1];
				sub_out_reg <= sub_n;
			end
		end
	end

	// Outputs straight from their registers
	assign dac_valid_o = valid_reg;
	assign dac_o = dac_reg;
	assign sub_o = sub_out_reg;
	assign sub_dac_en_o = ctrl_reg.sub_on; // R16
	assign analog_atten_o = analog_atten_reg;
	assign analog_mute_o = analog_mute_reg;
endmodule

/* File: test/audbp_chk.sv */
// Port-level assertions of the audio baseband processor
module audbp_chk (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// APB register port
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Stream and converter side
	input wire logic smp_valid_i,
	input wire logic dac_valid_o,
	input wire audbp_pkg::audbp_stereo_type dac_o,
	input wire logic signed [15:0] sub_o,
	input wire logic sub_dac_en_o,
	input wire logic [4:0] analog_atten_o,
	input wire logic analog_mute_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	apb_ready_a: assert property (pready_o == (psel_i && penable_i))
		else $error("pready not equal to access phase");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error outside access phase");
	unmapped_err_a: assert property (psel_i && !penable_i && paddr_i == 8'h18 |=> pslverr_o || !pready_o)
		else $error("unmapped access without error");
	mapped_ok_a: assert property (psel_i && !penable_i && paddr_i == audbp_pkg::ADDR_CTRL |=> !pslverr_o)
		else $error("mapped access flagged as error");
	dac_pulse_a: assert property (smp_valid_i |=> dac_valid_o)
		else $error("no output one clock after sample");
	dac_quiet_a: assert property (!smp_valid_i |=> !dac_valid_o)
		else $error("output strobe without sample");
	dac_hold_a: assert property (!smp_valid_i |=> $stable(dac_o) && $stable(sub_o))
		else $error("outputs changed between samples");
	sub_off_a: assert property (dac_valid_o && !$past(sub_dac_en_o) |-> sub_o == 16'sh0000)
		else $error("subwoofer sample while converter off");
	sub_en_a: assert property ($changed(sub_dac_en_o)
		|-> $past(psel_i && penable_i && pwrite_i && paddr_i == audbp_pkg::ADDR_CTRL))
		else $error("converter enable changed without control write");
	atten_range_a: assert property (analog_atten_o <= 5'd19)
		else $error("analog attenuation code out of range");
	mute_code_a: assert property (analog_mute_o |-> analog_atten_o == 5'd19)
		else $error("muted without full analog attenuation");
	atten_hold_a: assert property (!smp_valid_i |=> $stable(analog_atten_o))
		else $error("analog attenuation changed between samples");
endmodule

/* File: test/audbp_stream_src.sv */
// Stream source and converter sink facing the audio baseband processor
module audbp_stream_src (
	// Clock
	input wire logic clock_i,
	// Playback and record streams
	output logic smp_valid_o,
	output audbp_pkg::audbp_stereo_type smp_o,
	output logic adc_valid_o,
	output audbp_pkg::audbp_stereo_type adc_o,
	// Converter side
	input wire logic dac_valid_i,
	input wire audbp_pkg::audbp_stereo_type dac_i,
	input wire logic signed [15:0] sub_i
);
	timeunit 1ns;
	timeprecision 1ps;
	audbp_pkg::audbp_stereo_type last_out;
	logic signed [15:0] last_sub;

	initial
	begin
		smp_valid_o = 1'b0;
		smp_o = '0;
		adc_valid_o = 1'b0;
		adc_o = '0;
	end

	// One stereo sample per frame strobe, idle data lines inverted
	task automatic push(input logic signed [15:0] l, input logic signed [15:0] r, input int gap);
		smp_valid_o <= 1'b1;
		smp_o <= {l, r};
		adc_valid_o <= 1'b1;
		adc_o <= {r, l};
		@(posedge clock_i);
		smp_valid_o <= 1'b0;
		smp_o <= ~{l, r};
		adc_valid_o <= 1'b0;
		adc_o <= ~{r, l};
		repeat (gap + 2) @(posedge clock_i);
	endtask

	always @(posedge clock_i)
	begin
		if (dac_valid_i)
		begin
			last_out <= dac_i;
			last_sub <= sub_i;
		end
	end
endmodule

/* File: test/audbp_top_tb.sv */
// Self-checking bench of the audio baseband processor
module audbp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, rst_i, psel_i, penable_i, pwrite_i, err;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic pready_o, pslverr_o, smp_valid_i, adc_valid_i, dac_valid_o, sub_dac_en_o, analog_mute_o;
	audbp_pkg::audbp_stereo_type smp_i, adc_i, dac_o;
	logic signed [15:0] sub_o;
	logic [4:0] analog_atten_o;
	int err_total, checked, cycles, gl, gr, tl, tr, in_l, in_r, vol, pk;

	audbp_top DUT (.clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.smp_valid_i(smp_valid_i), .smp_i(smp_i), .adc_valid_i(adc_valid_i), .adc_i(adc_i),
		.dac_valid_o(dac_valid_o), .dac_o(dac_o), .sub_o(sub_o), .sub_dac_en_o(sub_dac_en_o),
		.analog_atten_o(analog_atten_o), .analog_mute_o(analog_mute_o));
	audbp_stream_src SRC (.clock_i(clock_i), .smp_valid_o(smp_valid_i), .smp_o(smp_i), .adc_valid_o(adc_valid_i),
		.adc_o(adc_i), .dac_valid_i(dac_valid_o), .dac_i(dac_o), .sub_i(sub_o));

	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 80000)
		begin
			err_total++;
			finish_test();
		end
	end

	task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_smp(input int exp, input logic signed [15:0] got);
		int d;
		d = int'(got) - exp;
		checked++;
		if ((^got === 1'bx) || d > 4 || d < -4)
		begin
			err_total++;
			$display("mismatch at %0t: sample %0d expected %0d", $time, got, exp);
		end
	endtask

	// APB transfer: setup, then access until pready at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clock_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 50);
		if (n == 50)
		begin
			err_total++;
			$display("mismatch at %0t: no pready", $time);
			finish_test();
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk_word(exp, rd);
	endtask

	function automatic int step(input int g, input int t);
		if (t > g + 16)
			return g + 16;
		if (t < g - 16)
			return g - 16;
		return t;
	endfunction

	function automatic logic [31:0] gain_word(input int atten);
		return (32'(atten) << 16) | 32'(gl);
	endfunction

	// Volume, mute and balance with the expected digital targets
	task automatic set_vol(input int v, input int mute, input int bal);
		tr = (mute != 0 || v > 114) ? 0 : audbp_pkg::DB_DOWN[v % 6];
		tl = (mute != 0 || v > 114) ? 0 : audbp_pkg::DB_DOWN[(v % 6 + bal) % 6] >> ((v % 6 + bal) / 6);
		apb(1'b1, audbp_pkg::ADDR_CTRL, 32'h0000_4200 | 32'(mute << 7) | 32'(v));
		apb(1'b1, audbp_pkg::ADDR_TONE, 32'(bal) << 16);
	endtask

	task automatic run(input int n);
		int pv;
		for (int i = 0; i < n; i++)
		begin
			in_l = int'($urandom % 16001) - 8000;
			in_r = int'($urandom % 16001) - 8000;
			SRC.push(16'(in_l), 16'(in_r), int'($urandom % 3));
			gl = step(gl, tl);
			gr = step(gr, tr);
			pv = (in_l < 0) ? -in_l : in_l;
			if (in_r > pv || -in_r > pv)
				pv = (in_r < 0) ? -in_r : in_r;
			pv = pv << 8;
			pk = (pv > pk) ? pk + ((pv - pk) >> audbp_pkg::QP_ATK_SH) : pk - (pk >> audbp_pkg::QP_DEC_SH);
		end
	endtask

	task automatic chk_out();
		chk_smp(in_l * gl / 4096, SRC.last_out.l);
		chk_smp(in_r * gr / 4096, SRC.last_out.r);
	endtask

	initial
	begin
		int seed;
		rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		seed = $urandom(32'h2e49);
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rchk(audbp_pkg::ADDR_CTRL, 32'h0000_6200);
		rchk(audbp_pkg::ADDR_TONE, 32'h0000_0000);
		rchk(audbp_pkg::ADDR_SUB, 32'h0000_0180);
		rchk(audbp_pkg::ADDR_AGC, 32'h1000_4000);
		rchk(audbp_pkg::ADDR_PEAK, 32'h0000_0000);
		for (int b = 0; b < 5; b++)
			rchk(audbp_pkg::ADDR_EQ + 8'(4 * b), {audbp_pkg::EQ_ALPHA_RST[b], 16'h0000});
		rchk(8'h18, 32'h0000_0000);
		chk_word(32'(err), 32'h0000_0001);
		apb(1'b1, audbp_pkg::ADDR_TONE, 32'hffff_ffff);
		rchk(audbp_pkg::ADDR_TONE, 32'h00ff_1f1f);
		chk_word(32'(sub_dac_en_o), 32'h0000_0001);
		$display("test registers done");
		set_vol(0, 0, 0);
		run(100);
		rchk(audbp_pkg::ADDR_GAIN, gain_word(0));
		run(200);
		rchk(audbp_pkg::ADDR_GAIN, gain_word(0));
		chk_out();
		$display("test ramp done");
		for (int i = 0; i < 4; i++)
		begin
			vol = (i == 0) ? 114 : int'($urandom % 115);
			set_vol(vol, 0, 0);
			run(8);
			rchk(audbp_pkg::ADDR_GAIN, gain_word(vol / 6));
			run(300);
			chk_word(32'(analog_atten_o), 32'(vol / 6));
			chk_out();
		end
		$display("test volume done");
		set_vol(0, 1, 0);
		run(10);
		chk_word(32'(analog_mute_o), 32'h0000_0000);
		run(260);
		rchk(audbp_pkg::ADDR_GAIN, gain_word(19));
		chk_word(32'(analog_mute_o), 32'h0000_0001);
		chk_out();
		set_vol(120, 0, 0);
		run(5);
		chk_word(32'(analog_mute_o), 32'h0000_0001);
		$display("test mute done");
		set_vol(0, 0, 6);
		run(300);
		rchk(audbp_pkg::ADDR_GAIN, gain_word(0));
		chk_out();
		apb(1'b0, audbp_pkg::ADDR_PEAK, 32'h0000_0000);
		chk_word(32'(pk >> 8), 32'(rd[15:0]));
		$display("test balance done");
		apb(1'b1, audbp_pkg::ADDR_CTRL, 32'h0000_4000);
		chk_word(32'(sub_dac_en_o), 32'h0000_0000);
		run(2);
		chk_smp(0, SRC.last_sub);
		apb(1'b1, audbp_pkg::ADDR_EQ + 8'h08, 32'h1234_5678);
		rchk(audbp_pkg::ADDR_EQ + 8'h08, 32'h1234_5678);
		apb(1'b1, audbp_pkg::ADDR_AGC, 32'hffff_ffff);
		rchk(audbp_pkg::ADDR_AGC, 32'h1000_ffff);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk_word(32'(sub_dac_en_o), 32'h0000_0001);
		rchk(audbp_pkg::ADDR_CTRL, 32'h0000_6200);
		rchk(audbp_pkg::ADDR_EQ + 8'h08, {audbp_pkg::EQ_ALPHA_RST[2], 16'h0000});
		$display("test subwoofer and reset done");
		finish_test();
	end
endmodule

bind audbp_top audbp_chk CHK (.clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.smp_valid_i(smp_valid_i), .dac_valid_o(dac_valid_o), .dac_o(dac_o), .sub_o(sub_o),
	.sub_dac_en_o(sub_dac_en_o), .analog_atten_o(analog_atten_o), .analog_mute_o(analog_mute_o));
